// file: logic/sbtc_pkg.sv
// Shared constants for the buffered SPI transfer controller and its peer
package sbtc_pkg;
  // -------------------------------------------------------------------
  // Register offsets on the local software port
  // -------------------------------------------------------------------
  localparam logic [1:0] ADDR_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_IRQEN = 2'h1;
  localparam logic [1:0] ADDR_FLAGS = 2'h2;
  localparam logic [1:0] ADDR_DATA  = 2'h3;
  // -------------------------------------------------------------------
  // Control register fields
  // -------------------------------------------------------------------
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_HOST     = 1;
  localparam int CTL_BUFFER_MODE_ENABLE    = 2;
  localparam int CTL_WFR      = 3;
  localparam int CTL_SSD      = 4;
  localparam int CTL_SS_OUT   = 5;
  localparam int CTL_MISO_OUT = 6;
  localparam logic [6:0] CTL_RESET = 7'h00;
  // -------------------------------------------------------------------
  // Interrupt enable and flag fields
  // -------------------------------------------------------------------
  localparam int IE_DONE = 0;
  localparam int IE_TXC  = 1;
  localparam int IE_RXC  = 2;
  localparam int IE_DRE  = 3;
  localparam int FL_DONE = 0;
  localparam int FL_WCOL = 1;
  localparam int FL_DRE  = 2;
  localparam int FL_TXC  = 3;
  localparam int FL_RXC  = 4;
  localparam logic [3:0] IE_RESET = 4'h0;
  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int HOST_HALF_NS = 40;
  localparam int PEER_HALF_NS = 62;
  localparam logic [3:0] HOST_HALF_CYC = 4'(HOST_HALF_NS / CLK_NS);
  localparam logic [3:0] PEER_HALF_CYC = 4'(PEER_HALF_NS / CLK_NS);
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

// file: logic/sbtc_if.sv
// Pin-level link between the controller and the far SPI party
`timescale 1ns/10ps
interface sbtc_if;
  logic dev_sck,  dev_sck_oe_n,  peer_sck,  peer_sck_oe_n;
  logic dev_mosi, dev_mosi_oe_n, peer_mosi, peer_mosi_oe_n;
  logic dev_miso, dev_miso_oe_n, peer_miso, peer_miso_oe_n;
  logic peer_ss;
  logic sck, mosi, miso, ss;

  // -------------------------------------------------------------------
  // Wire resolution, idle lines pull to fixed levels
  // -------------------------------------------------------------------
  assign sck  = !dev_sck_oe_n ? dev_sck :
                (!peer_sck_oe_n ? peer_sck : 1'b0);
  assign mosi = !dev_mosi_oe_n ? dev_mosi :
                (!peer_mosi_oe_n ? peer_mosi : 1'b1);
  assign miso = !dev_miso_oe_n ? dev_miso :
                (!peer_miso_oe_n ? peer_miso : 1'b1);
  assign ss   = peer_ss;

  modport dev (output dev_sck, dev_sck_oe_n, dev_mosi, dev_mosi_oe_n,
               output dev_miso, dev_miso_oe_n,
               input  sck, mosi, miso, ss);
  modport peer (output peer_sck, peer_sck_oe_n, peer_mosi, peer_mosi_oe_n,
                output peer_miso, peer_miso_oe_n, peer_ss,
                input  sck, mosi, miso);
endinterface

// file: logic/sbtc_peer.sv
// Far SPI party: plays host or selected client against the controller
`timescale 1ns/10ps
module sbtc_peer (
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_i,   // Synchronous reset
  input  wire logic       ce_i,    // Clock enable
  sbtc_if.peer            bus,     // SPI pins
  input  wire logic       host_i,  // 1: peer drives the clock
  input  wire logic       start_i, // Host: start byte, client: load byte
  input  wire logic [7:0] tx_i,    // Byte to send
  output logic      [7:0] rx_o,    // Last byte received
  output logic            done_o,  // One-cycle end of byte
  output logic            busy_o   // Host exchange running
);
  typedef enum logic [1:0] {SBTC_P_IDLE, SBTC_P_RUN, SBTC_P_TAIL} sbtc_pst_t;
  sbtc_pst_t   st, next_st;
  logic [2:0]  s1, s2;
  logic        sck_p, next_sck_p;
  logic [7:0]  sr, next_sr, next_rx;
  logic        lat, next_lat, sck_q, next_sck_q, done, next_done;
  logic [2:0]  cnt, next_cnt;
  logic [3:0]  div, next_div;
  logic        rise, fall;

  // -------------------------------------------------------------------
  // Pin synchronisers: sck, mosi, miso
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
    end else if (ce_i) begin
      s1 <= {bus.sck, bus.mosi, bus.miso};
      s2 <= s1;
    end
  end

  assign rise = s2[2] && !sck_p;
  assign fall = !s2[2] && sck_p;

  // -------------------------------------------------------------------
  // Byte engine, mode 0, MSB first
  // -------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_sr = sr;
    next_lat = lat;
    next_cnt = cnt;
    next_div = div;
    next_sck_q = sck_q;
    next_sck_p = s2[2];
    next_done = 1'b0;
    next_rx = rx_o;
    if (host_i) begin
      unique case (st)
        SBTC_P_IDLE: begin
          next_sck_q = 1'b0;
          if (start_i) begin
            next_sr = tx_i;
            next_cnt = 3'h0;
            next_div = 4'h0;
            next_st = SBTC_P_RUN;
          end
        end
        SBTC_P_RUN: begin
          // Half period kept above two device cycles
          if (div == sbtc_pkg::PEER_HALF_CYC - 4'h1) begin
            next_div = 4'h0;
            next_sck_q = !sck_q;
            if (!sck_q) begin
              next_lat = s2[0];
            end else begin
              next_sr = {sr[6:0], lat};
              next_cnt = cnt + 3'h1;
              if (cnt == sbtc_pkg::LAST_BIT) begin
                next_rx = {sr[6:0], lat};
                next_st = SBTC_P_TAIL;
              end
            end
          end else begin
            next_div = div + 4'h1;
          end
        end
        // Select stays low a half period past the last edge, so the
        // far end sees that edge before it is deselected
        SBTC_P_TAIL: begin
          if (div == sbtc_pkg::PEER_HALF_CYC - 4'h1) begin
            next_done = 1'b1;
            next_st = SBTC_P_IDLE;
          end else begin
            next_div = div + 4'h1;
          end
        end
        default: next_st = SBTC_P_IDLE;
      endcase
    end else begin
      next_st = SBTC_P_IDLE;
      next_sck_q = 1'b0;
      if (start_i) begin
        next_sr = tx_i;
      end else if (rise) begin
        next_lat = s2[1];
      end else if (fall) begin
        next_sr = {sr[6:0], lat};
        next_cnt = cnt + 3'h1;
        if (cnt == sbtc_pkg::LAST_BIT) begin
          next_done = 1'b1;
          next_rx = {sr[6:0], lat};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= SBTC_P_IDLE;
      sr <= 8'h00;
      lat <= 1'b0;
      cnt <= 3'h0;
      div <= 4'h0;
      sck_q <= 1'b0;
      sck_p <= 1'b0;
      done_o <= 1'b0;
      rx_o <= 8'h00;
    end else if (ce_i) begin
      st <= next_st;
      sr <= next_sr;
      lat <= next_lat;
      cnt <= next_cnt;
      div <= next_div;
      sck_q <= next_sck_q;
      sck_p <= next_sck_p;
      done_o <= next_done;
      rx_o <= next_rx;
    end
  end

  assign busy_o = (st != SBTC_P_IDLE);
  assign bus.peer_ss = !(host_i && st != SBTC_P_IDLE);
  assign bus.peer_sck = sck_q;
  assign bus.peer_sck_oe_n = !host_i;
  assign bus.peer_mosi = sr[7];
  assign bus.peer_mosi_oe_n = !host_i;
  assign bus.peer_miso = sr[7];
  assign bus.peer_miso_oe_n = host_i;
endmodule

// file: logic/sbtc_device.sv
// Buffered SPI transfer controller, host or client role
`timescale 1ns/10ps
module sbtc_device (
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_i,   // Synchronous reset
  input  wire logic       ce_i,    // Clock enable
  input  wire logic [1:0] addr_i,  // Register address
  input  wire logic [7:0] wdata_i, // Write data
  input  wire logic       wr_i,    // Write strobe
  input  wire logic       rd_i,    // Read strobe
  output logic      [7:0] rdata_o, // Read data, cycle after strobe
  output logic            irq_o,   // Interrupt request
  sbtc_if.dev             bus      // SPI pins
);
  typedef enum logic {SBTC_H_IDLE, SBTC_H_RUN} sbtc_hst_t;
  sbtc_hst_t   hst, next_hst;
  logic [3:0]  s1, s2;             // sck, ss, mosi, miso
  logic        sck_p, next_sck_p;
  logic [6:0]  ctl, next_ctl;
  logic [3:0]  ien, next_ien;
  logic [4:0]  fl, next_fl;
  logic [7:0]  sr, next_sr, txb, next_txb, rxd, next_rxd, next_rdata;
  logic        txfull, next_txfull, fresh, next_fresh;
  logic        lat, next_lat, sck_q, next_sck_q;
  logic [2:0]  cnt, next_cnt;
  logic [3:0]  div, next_div;
  logic [7:0]  rxq [2];
  logic [7:0]  next_rxq [2];
  logic [1:0]  rxn, next_rxn;
  logic        d1, next_d1, d2, next_d2;
  logic        host, bufm, rise, fall, ss_low, busy, shift_end;
  logic [7:0]  in_byte;

  // -------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 4'h4;
      s2 <= 4'h4;
    end else if (ce_i) begin
      s1 <= {bus.sck, bus.ss, bus.mosi, bus.miso};
      s2 <= s1;
    end
  end

  assign host = ctl[sbtc_pkg::CTL_HOST];
  assign bufm = ctl[sbtc_pkg::CTL_BUFFER_MODE_ENABLE];
  assign ss_low = !s2[2];
  assign rise = s2[3] && !sck_p && ss_low;
  assign fall = !s2[3] && sck_p && ss_low;
  assign busy = host ? (hst == SBTC_H_RUN) : (cnt != 3'h0);
  assign shift_end = host
      ? (hst == SBTC_H_RUN && sck_q && div == sbtc_pkg::HOST_HALF_CYC - 4'h1
         && cnt == sbtc_pkg::LAST_BIT)
      : (fall && cnt == sbtc_pkg::LAST_BIT);
  // Host takes the reply bit straight from the synchroniser
  assign in_byte = host ? {sr[6:0], s2[0]} : {sr[6:0], lat};

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    next_hst = hst;
    next_ctl = ctl;
    next_ien = ien;
    next_fl = fl;
    next_sr = sr;
    next_txb = txb;
    next_txfull = txfull;
    next_fresh = fresh;
    next_lat = lat;
    next_sck_q = sck_q;
    next_sck_p = s2[3];
    next_cnt = cnt;
    next_div = div;
    next_rxd = rxd;
    next_rxq = rxq;
    next_rxn = rxn;
    next_d1 = 1'b0;
    next_d2 = d1;
    next_rdata = 8'h00;

    // Shifting engine
    if (host) begin
      if (hst == SBTC_H_RUN) begin
        if (div == sbtc_pkg::HOST_HALF_CYC - 4'h1) begin
          next_div = 4'h0;
          next_sck_q = !sck_q;
          // Reply moves three cycles after our falling edge and reaches s2 after five,
          // too late for the rising edge; take it at the next fall
          if (sck_q) begin
            next_sr = in_byte;
            next_cnt = cnt + 3'h1;
            if (cnt == sbtc_pkg::LAST_BIT) begin
              next_hst = SBTC_H_IDLE;
            end
          end
        end else begin
          next_div = div + 4'h1;
        end
      end
    end else if (!ss_low) begin
      next_cnt = 3'h0;
    end else if (rise) begin
      next_lat = s2[1];
    end else if (fall) begin
      next_sr = in_byte;
      next_cnt = cnt + 3'h1;
    end

    // End of byte: store received data, reload from buffer
    if (shift_end) begin
      next_fresh = 1'b0;
      if (!bufm) begin
        next_rxd = in_byte;
        next_fl[sbtc_pkg::FL_DONE] = 1'b1;
      end else begin
        next_d1 = 1'b1;
        if (rxn != 2'h2) begin
          next_rxq[rxn[0]] = in_byte;
          next_rxn = rxn + 2'h1;
        end
        if (txfull) begin
          next_sr = txb;
          next_txfull = 1'b0;
          next_fresh = 1'b1;
          next_fl[sbtc_pkg::FL_DRE] = 1'b1;
          if (host) begin
            next_hst = SBTC_H_RUN;
            next_cnt = 3'h0;
            next_div = 4'h0;
          end
        end
      end
    end

    // Flags trail a buffered end of byte by one and two cycles
    if (d1) begin
      next_fl[sbtc_pkg::FL_RXC] = 1'b1;
    end
    if (d2 && !txfull && !busy) begin
      next_fl[sbtc_pkg::FL_TXC] = 1'b1;
    end

    // Software port; flag clears lose to a hardware set
    if (rd_i) begin
      unique case (addr_i)
        sbtc_pkg::ADDR_CTRL:  next_rdata = {1'b0, ctl};
        sbtc_pkg::ADDR_IRQEN: next_rdata = {4'h0, ien};
        sbtc_pkg::ADDR_FLAGS: next_rdata = {3'h0, fl};
        sbtc_pkg::ADDR_DATA: begin
          if (!bufm) begin
            next_rdata = rxd;
          end else begin
            next_rdata = rxq[0];
            if (rxn != 2'h0) begin
              next_rxq[0] = shift_end && rxn == 2'h1 ? in_byte : rxq[1];
              next_rxn = next_rxn - 2'h1;
            end
          end
        end
      endcase
    end
    if (wr_i) begin
      unique case (addr_i)
        sbtc_pkg::ADDR_CTRL:  next_ctl = wdata_i[6:0];
        sbtc_pkg::ADDR_IRQEN: next_ien = wdata_i[3:0];
        sbtc_pkg::ADDR_FLAGS: next_fl = next_fl & ~(wdata_i[4:0] & ~(next_fl
                                  ^ fl));
        sbtc_pkg::ADDR_DATA: begin
          if (!bufm) begin
            if (busy) begin
              next_fl[sbtc_pkg::FL_WCOL] = 1'b1;
              if (host) begin
                next_sr = wdata_i;
              end
            end else begin
              next_sr = wdata_i;
              if (host) begin
                next_hst = SBTC_H_RUN;
                next_cnt = 3'h0;
                next_div = 4'h0;
              end
            end
          end else if (host && !busy && !txfull && !shift_end) begin
            next_sr = wdata_i;
            next_hst = SBTC_H_RUN;
            next_cnt = 3'h0;
            next_div = 4'h0;
            next_fl[sbtc_pkg::FL_TXC] = 1'b0;
          end else if (fl[sbtc_pkg::FL_DRE]) begin
            next_txb = wdata_i;
            next_txfull = 1'b1;
            next_fl[sbtc_pkg::FL_DRE] = 1'b0;
            next_fl[sbtc_pkg::FL_TXC] = 1'b0;
          end
        end
      endcase
    end

    // Wait-for-select client loads user data ahead of the first edge
    if (!host && bufm && ctl[sbtc_pkg::CTL_WFR] && cnt == 3'h0
        && !fresh && txfull && !fall) begin
      next_sr = txb;
      next_txfull = 1'b0;
      next_fresh = 1'b1;
      next_fl[sbtc_pkg::FL_DRE] = 1'b1;
    end

    // Multi-host arbitration; wait-for-select plays no part here
    if (host && !ctl[sbtc_pkg::CTL_SSD]
        && !ctl[sbtc_pkg::CTL_SS_OUT] && !s2[2]) begin
      next_ctl[sbtc_pkg::CTL_HOST] = 1'b0;
      next_fl[sbtc_pkg::FL_DONE] = 1'b1;
      next_hst = SBTC_H_IDLE;
      next_sck_q = 1'b0;
      next_cnt = 3'h0;
    end
    if (!ctl[sbtc_pkg::CTL_ENABLE]) begin
      next_hst = SBTC_H_IDLE;
      next_sck_q = 1'b0;
      next_cnt = 3'h0;
    end
  end

  // -------------------------------------------------------------------
  // State registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hst <= SBTC_H_IDLE;
      ctl <= sbtc_pkg::CTL_RESET;
      ien <= sbtc_pkg::IE_RESET;
      fl <= 5'h04;
      sr <= 8'h00;
      txb <= 8'h00;
      txfull <= 1'b0;
      fresh <= 1'b0;
      lat <= 1'b0;
      sck_q <= 1'b0;
      sck_p <= 1'b0;
      cnt <= 3'h0;
      div <= 4'h0;
      rxd <= 8'h00;
      rxq[0] <= 8'h00;
      rxq[1] <= 8'h00;
      rxn <= 2'h0;
      d1 <= 1'b0;
      d2 <= 1'b0;
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      hst <= next_hst;
      ctl <= next_ctl;
      ien <= next_ien;
      fl <= next_fl;
      sr <= next_sr;
      txb <= next_txb;
      txfull <= next_txfull;
      fresh <= next_fresh;
      lat <= next_lat;
      sck_q <= next_sck_q;
      sck_p <= next_sck_p;
      cnt <= next_cnt;
      div <= next_div;
      rxd <= next_rxd;
      rxq <= next_rxq;
      rxn <= next_rxn;
      d1 <= next_d1;
      d2 <= next_d2;
      rdata_o <= next_rdata;
    end
  end

  // -------------------------------------------------------------------
  // Interrupt and pins
  // -------------------------------------------------------------------
  assign irq_o = (fl[sbtc_pkg::FL_DONE] | fl[sbtc_pkg::FL_WCOL])
                   & ien[sbtc_pkg::IE_DONE]
               | fl[sbtc_pkg::FL_TXC] & ien[sbtc_pkg::IE_TXC]
               | fl[sbtc_pkg::FL_RXC] & ien[sbtc_pkg::IE_RXC]
               | fl[sbtc_pkg::FL_DRE] & ien[sbtc_pkg::IE_DRE];
  assign bus.dev_sck = sck_q;
  assign bus.dev_sck_oe_n = !(host && ctl[sbtc_pkg::CTL_ENABLE]);
  assign bus.dev_mosi = sr[7];
  assign bus.dev_mosi_oe_n = !(host && ctl[sbtc_pkg::CTL_ENABLE]);
  assign bus.dev_miso = sr[7];
  assign bus.dev_miso_oe_n = !(!host && ctl[sbtc_pkg::CTL_ENABLE]
                             && ctl[sbtc_pkg::CTL_MISO_OUT]
                             && ss_low);
endmodule

// file: tb/sbtc_monitor.sv
// Link checker watching the SPI pins between controller and peer
`timescale 1ns/10ps
module sbtc_monitor (
  input wire logic clk_i,          // System clock
  input wire logic rst_i,          // Synchronous reset
  input wire logic dev_sck,        // Controller clock out
  input wire logic dev_sck_oe_n,   // Controller clock enable
  input wire logic peer_sck_oe_n,  // Peer clock enable
  input wire logic dev_mosi,       // Controller data out
  input wire logic dev_mosi_oe_n,  // Controller data enable
  input wire logic peer_mosi_oe_n, // Peer data enable
  input wire logic dev_miso,       // Controller reply out
  input wire logic dev_miso_oe_n,  // Controller reply enable
  input wire logic peer_miso_oe_n, // Peer reply enable
  input wire logic sck,            // Resolved clock
  input wire logic ss              // Resolved select
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // Pin ownership
  // ------------------------------------------------------------
  // Short overlap allowed: demotion passes a two-flop synchroniser
  a_sck_contend: assert property (
    not ((!dev_sck_oe_n && !peer_sck_oe_n)[*6]))
    else $error("sck driven by both ends");
  a_mosi_contend: assert property (
    not ((!dev_mosi_oe_n && !peer_mosi_oe_n)[*6]))
    else $error("mosi driven by both ends");
  a_miso_contend: assert property (
    !(!dev_miso_oe_n && !peer_miso_oe_n))
    else $error("miso driven by both ends");
  a_miso_desel: assert property (ss[*4] |-> dev_miso_oe_n)
    else $error("miso driven while deselected");
  a_sck_release: assert property (
    $rose(dev_sck_oe_n) |-> !$past(dev_sck))
    else $error("sck released while high");
  // ------------------------------------------------------------
  // Bit timing
  // ------------------------------------------------------------
  a_sck_half: assert property (
    $rose(dev_sck) && !dev_sck_oe_n |=> dev_sck[*3] ##1 !dev_sck)
    else $error("host clock high phase not four cycles");
  a_mosi_hold: assert property (
    $rose(dev_sck) && !dev_mosi_oe_n |=> $stable(dev_mosi)[*3])
    else $error("mosi moved while clock high");
  a_miso_hold: assert property (
    $rose(sck) && !dev_miso_oe_n |=> $stable(dev_miso)[*4])
    else $error("miso moved while clock high");
  c_ss_low: cover property ($fell(ss));
  c_host_clk: cover property ($rose(dev_sck));
  c_client_out: cover property ($fell(dev_miso_oe_n));
endmodule

// file: tb/test_spi_buffered_transfer_control.sv
// Bench joining the controller to the far SPI party over the link
`timescale 1ns/10ps
module test_spi_buffered_transfer_control;
  localparam logic [1:0] CTL = sbtc_pkg::ADDR_CTRL;
  localparam logic [1:0] IEN = sbtc_pkg::ADDR_IRQEN;
  localparam logic [1:0] FLG = sbtc_pkg::ADDR_FLAGS;
  localparam logic [1:0] DAT = sbtc_pkg::ADDR_DATA;
  logic       clk_i     = 1'b0;
  logic       rst_i     = 1'b1;
  logic       ce_i      = 1'b1;
  logic [1:0] addr      = 2'h0;
  logic [7:0] wdata     = 8'h00;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic       p_host    = 1'b0;
  logic       p_start   = 1'b0;
  logic [7:0] p_tx      = 8'h00;
  logic [7:0] p_rx;
  logic       p_done;
  logic [7:0] v;
  int         error_cnt = 0;
  int         n_tests   = 0;

  always #5 clk_i = ~clk_i;

  sbtc_if bus_if ();
  sbtc_device u_sbtc_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq), .bus(bus_if));
  sbtc_peer u_sbtc_peer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .bus(bus_if), .host_i(p_host), .start_i(p_start), .tx_i(p_tx),
    .rx_o(p_rx), .done_o(p_done), .busy_o());
  sbtc_monitor u_sbtc_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .dev_sck(bus_if.dev_sck), .dev_sck_oe_n(bus_if.dev_sck_oe_n),
    .peer_sck_oe_n(bus_if.peer_sck_oe_n), .dev_mosi(bus_if.dev_mosi),
    .dev_mosi_oe_n(bus_if.dev_mosi_oe_n),
    .peer_mosi_oe_n(bus_if.peer_mosi_oe_n), .dev_miso(bus_if.dev_miso),
    .dev_miso_oe_n(bus_if.dev_miso_oe_n),
    .peer_miso_oe_n(bus_if.peer_miso_oe_n), .sck(bus_if.sck),
    .ss(bus_if.ss));
  // ------------------------------------------------------------
  // Bus cycles and comparisons
  // ------------------------------------------------------------
  task automatic chk8(input string w, input logic [7:0] e,
                      input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk1(input string w, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", w, e, g);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded poll: after 100 reads a flag that never comes is left clear in v
  task automatic poll(input int b);
    for (int i = 0; i < 100; i++) begin
      rd_reg(FLG);
      if (v[b] === 1'b1) break;
    end
  endtask
  // Peer as host runs one byte; as client it only loads its byte
  task automatic peer_go(input logic h, input logic [7:0] b);
    @(posedge clk_i);
    p_host  <= h;
    p_tx    <= b;
    p_start <= 1'b1;
    @(posedge clk_i);
    p_start <= 1'b0;
    for (int i = 0; h && i < 300; i++) begin
      @(posedge clk_i);
      #1 if (p_done === 1'b1) break;
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd_reg(CTL);
    chk8("ctrl", 8'h00, v);
    rd_reg(IEN);
    chk8("irqen", 8'h00, v);
    rd_reg(FLG);
    chk8("flags", 8'h04, v);
    $display("reset test done");
  endtask
  task automatic t_host_normal;
    peer_go(1'b0, 8'h3c);
    wr_reg(IEN, 8'h01);
    wr_reg(CTL, 8'h03);
    wr_reg(DAT, 8'ha5);
    poll(sbtc_pkg::FL_DONE);
    chk1("done", 1'b1, v[sbtc_pkg::FL_DONE]);
    chk1("irq", 1'b1, irq);
    // Peer sees the last edge through its own synchroniser
    repeat (4) @(posedge clk_i);
    #1;
    chk8("peer rx", 8'ha5, p_rx);
    rd_reg(DAT);
    chk8("rx data", 8'h3c, v);
    wr_reg(FLG, 8'h1b);
    chk1("irq off", 1'b0, irq);
    wr_reg(DAT, 8'h55);
    wr_reg(DAT, 8'h66);
    poll(sbtc_pkg::FL_DONE);
    chk1("wcol", 1'b1, v[sbtc_pkg::FL_WCOL]);
    $display("host normal test done");
  endtask
  task automatic t_host_buffer;
    wr_reg(FLG, 8'h1b);
    peer_go(1'b0, 8'h5a);
    wr_reg(CTL, 8'h07);
    wr_reg(DAT, 8'h81);
    wr_reg(DAT, 8'h42);
    rd_reg(FLG);
    chk1("empty low", 1'b0, v[sbtc_pkg::FL_DRE]);
    poll(sbtc_pkg::FL_TXC);
    chk1("txc", 1'b1, v[sbtc_pkg::FL_TXC]);
    chk8("peer rx", 8'h42, p_rx);
    rd_reg(DAT);
    chk8("queue 0", 8'h5a, v);
    rd_reg(DAT);
    chk8("queue 1", 8'h81, v);
    $display("host buffer test done");
  endtask
  task automatic t_arbitration;
    wr_reg(CTL, 8'h03);
    wr_reg(FLG, 8'h1b);
    peer_go(1'b1, 8'h96);
    rd_reg(CTL);
    chk1("host bit", 1'b0, v[sbtc_pkg::CTL_HOST]);
    rd_reg(FLG);
    chk1("done", 1'b1, v[sbtc_pkg::FL_DONE]);
    $display("arbitration test done");
  endtask
  task automatic t_client_normal;
    wr_reg(CTL, 8'h41);
    wr_reg(FLG, 8'h1b);
    wr_reg(DAT, 8'hc3);
    fork
      peer_go(1'b1, 8'h3a);
      begin
        repeat (30) @(posedge clk_i);
        wr_reg(DAT, 8'h77);
      end
    join
    chk8("peer rx", 8'hc3, p_rx);
    poll(sbtc_pkg::FL_DONE);
    chk1("wcol", 1'b1, v[sbtc_pkg::FL_WCOL]);
    chk1("miso off", 1'b1, bus_if.dev_miso_oe_n);
    rd_reg(DAT);
    chk8("rx data", 8'h3a, v);
    $display("client normal test done");
  endtask
  task automatic t_client_dummy;
    wr_reg(CTL, 8'h45);
    wr_reg(FLG, 8'h1b);
    wr_reg(DAT, 8'h43);
    peer_go(1'b1, 8'h00);
    chk8("dummy", 8'h3a, p_rx);
    wr_reg(DAT, 8'h44);
    rd_reg(FLG);
    chk1("empty low", 1'b0, v[sbtc_pkg::FL_DRE]);
    wr_reg(DAT, 8'h45);
    wr_reg(FLG, 8'h1b);
    peer_go(1'b1, 8'h00);
    chk8("byte 1", 8'h43, p_rx);
    poll(sbtc_pkg::FL_RXC);
    chk1("empty high", 1'b1, v[sbtc_pkg::FL_DRE]);
    peer_go(1'b1, 8'h00);
    chk8("byte 2", 8'h44, p_rx);
    poll(sbtc_pkg::FL_TXC);
    chk1("txc", 1'b1, v[sbtc_pkg::FL_TXC]);
    $display("client dummy test done");
  endtask
  task automatic t_client_wait;
    wr_reg(CTL, 8'h4d);
    wr_reg(DAT, 8'h5e);
    peer_go(1'b1, 8'h00);
    chk8("first", 8'h5e, p_rx);
    $display("client wait test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_host_normal;
    t_host_buffer;
    t_arbitration;
    t_client_normal;
    t_client_dummy;
    t_client_wait;
    print_verdict;
  end
  // Run needs about 1000 cycles; stop a hang well beyond that
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
endmodule
